/* bench/rcs_host_model.sv */
`timescale 1ns/1ps
module rcs_host_model
#(
  parameter LW = 10,
  parameter DEPTH = 16
)
(
  input wire clk,
  input wire ld,
  input wire [7:0] ld_data,
  input wire clr,
  input wire [3:0] ee_lat,
  input wire fifo_pop,
  input wire fifo_push,
  input wire [7:0] fifo_wdata,
  output logic [7:0] fifo_rdata,
  output logic fifo_empty,
  output logic fifo_full,
  output logic [LW-1:0] fifo_level,
  input wire ee_req,
  input wire ee_we,
  input wire [12:0] ee_addr,
  input wire [7:0] ee_wdata,
  output logic ee_ack,
  output logic [7:0] ee_rdata,
  output logic rng_valid,
  output logic [7:0] rng_data
);
  logic [7:0] q[$];
  logic [7:0] mem [0:8191];
  logic [3:0] cnt;
  initial
  begin
    for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'hA5;
    {fifo_rdata, fifo_full, fifo_level, ee_ack, ee_rdata} = '0;
    {fifo_empty, rng_valid, rng_data, cnt} = {1'b1, 13'h0000};
  end
  // ----------------------------------------
  // fifo, flags follow one cycle later
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (clr) q.delete();
    if (fifo_pop && q.size() > 0) void'(q.pop_front());
    if (fifo_push && q.size() < DEPTH) q.push_back(fifo_wdata);
    if (ld) q.push_back(ld_data);
    fifo_empty <= (q.size() == 0);
    fifo_full <= (q.size() >= DEPTH);
    fifo_level <= LW'(q.size());
    // empty head toggles so stale data is never mistaken for valid
    fifo_rdata <= (q.size() > 0) ? q[0] : ~fifo_rdata;
    rng_valid <= ~rng_valid;
    rng_data <= rng_data + 8'h01;
  end
  // ----------------------------------------
  // eeprom, latency set by bench
  // ----------------------------------------
  always @(posedge clk)
  begin
    ee_ack <= 1'b0;
    ee_rdata <= ~ee_rdata;
    if (ee_req && !ee_ack && cnt >= ee_lat)
    begin
      ee_ack <= 1'b1;
      cnt <= 4'h0;
      if (ee_we) mem[ee_addr] <= ee_wdata;
      else ee_rdata <= mem[ee_addr];
    end
    else if (ee_req && !ee_ack) cnt <= cnt + 4'h1;
    else cnt <= 4'h0;
  end
endmodule // rcs_host_model

/* bench/rcs_sequencer_sva.sv */
`timescale 1ns/1ps
module rcs_sequencer_sva
(
  input wire CLK_SYS,
  input wire RST_N,
  input wire CMD_WR,
  input wire [7:0] CMD_WDATA,
  input wire [7:0] CMD_VALUE,
  input wire CMD_ABORT,
  input wire MULTI_FRAME_RECEIVE,
  input wire FIFO_EMPTY,
  input wire TX_EN,
  input wire TX_IDLE,
  input wire RX_EN,
  input wire RX_DONE,
  input wire EE_REQ,
  input wire EE_WE,
  input wire [12:0] EE_ADDR,
  input wire EE_ACK
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence trx_tx_ends;
    (TX_EN && CMD_VALUE == 8'h07 && !CMD_WR) ##1 (!TX_EN && !CMD_WR);
  endsequence
  sequence tx_cmd_written;
    CMD_WR && (CMD_WDATA == 8'h06 || CMD_WDATA == 8'h07);
  endsequence
  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_cmd_echo: assert property (
    CMD_WR |=> CMD_VALUE == $past(CMD_WDATA))
    else $error("command value does not follow write");
  chk_tx_start: assert property (tx_cmd_written |=> TX_EN)
    else $error("transmit not started at once");
  chk_tx_cause: assert property ($rose(TX_EN) |-> $past(CMD_WR))
    else $error("transmit started without command write");
  chk_tx_end: assert property (
    TX_EN && FIFO_EMPTY && TX_IDLE && !CMD_WR |-> ##[1:3] !TX_EN)
    else $error("transmit did not end on empty fifo");
  chk_new_cmd_stop: assert property (CMD_WR &&
    CMD_WDATA != 8'h06 && CMD_WDATA != 8'h07 |=> !TX_EN && !RX_EN && !EE_REQ)
    else $error("new command did not stop activity");
  chk_abort_idle: assert property (CMD_ABORT |-> CMD_VALUE == 8'h00)
    else $error("abort without idle command value");
  chk_trx_receive: assert property (trx_tx_ends |-> ##[0:2] RX_EN)
    else $error("receiver not enabled after transmit");
  chk_multi_stay: assert property (
    RX_EN && MULTI_FRAME_RECEIVE && !CMD_WR |=> RX_EN)
    else $error("multi-frame receive left");
  chk_rx_end: assert property (
    RX_EN && RX_DONE && !MULTI_FRAME_RECEIVE && !CMD_WR |-> ##[1:3] !RX_EN)
    else $error("receive did not end on frame end");
  chk_ee_hold: assert property (EE_REQ && !EE_ACK && !CMD_WR
    |=> EE_REQ && $stable(EE_ADDR) && $stable(EE_WE))
    else $error("eeprom request dropped before ack");
endmodule // rcs_sequencer_sva

bind rcs_sequencer rcs_sequencer_sva u_sva (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .CMD_WR(CMD_WR), .CMD_WDATA(CMD_WDATA), .CMD_VALUE(CMD_VALUE),
  .CMD_ABORT(CMD_ABORT), .MULTI_FRAME_RECEIVE(MULTI_FRAME_RECEIVE),
  .FIFO_EMPTY(FIFO_EMPTY), .TX_EN(TX_EN), .TX_IDLE(TX_IDLE), .RX_EN(RX_EN),
  .RX_DONE(RX_DONE), .EE_REQ(EE_REQ), .EE_WE(EE_WE), .EE_ADDR(EE_ADDR),
  .EE_ACK(EE_ACK));

/* bench/reader_command_sequencer_bench.sv */
`timescale 1ns/1ps
module reader_command_sequencer_bench;
  typedef struct packed {
    logic [7:0] code;
    logic ab;
    logic [7:0] nreg;
    logic [7:0] npush;
  } rcs_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_wr = 1'b0;
  logic [7:0] cmd_wdata = 8'h00;
  logic multi = 1'b0;
  logic tx_idle = 1'b1;
  logic rx_done = 1'b0;
  logic ld = 1'b0;
  logic [7:0] ld_data = 8'h00;
  logic clr = 1'b0;
  logic [3:0] ee_lat = 4'h1;
  wire [7:0] cmd_value, f_rd, f_wd, ee_wd, ee_rd, reg_addr, reg_wd, key_wd;
  wire [7:0] rng_data;
  wire [9:0] f_lvl;
  wire [12:0] ee_addr;
  wire abort, f_empty, f_full, pop, push, tx_en, rx_en, ee_req, ee_we, ee_ack;
  wire reg_we, key_we, rng_valid;
  wire [2:0] key_ix;
  int err_total = 0;
  int check_count = 0;
  int n_abort, n_reg, n_key;
  logic [15:0] last_reg;
  logic [10:0] last_key;
  logic [7:0] pq[$];
  rcs_row_t rows [0:7] = '{'{8'h09, 1'b1, 8'h00, 8'h00},
    '{8'h0A, 1'b1, 8'h00, 8'h00}, '{8'h0C, 1'b1, 8'h00, 8'h00},
    '{8'h0D, 1'b1, 8'h00, 8'h00}, '{8'h0E, 1'b1, 8'h00, 8'h00},
    '{8'h0F, 1'b1, 8'h00, 8'h00}, '{8'h1C, 1'b0, 8'h00, 8'h10},
    '{8'h1F, 1'b0, 8'h7F, 8'h00}};
  always #2.5 clk = ~clk;

  rcs_sequencer dut (.CLK_SYS(clk), .RST_N(rst_n), .CMD_WR(cmd_wr),
    .CMD_WDATA(cmd_wdata), .CMD_VALUE(cmd_value), .CMD_ABORT(abort),
    .MULTI_FRAME_RECEIVE(multi), .FIFO_RDATA(f_rd), .FIFO_EMPTY(f_empty),
    .FIFO_FULL(f_full), .FIFO_LEVEL(f_lvl), .FIFO_POP(pop), .FIFO_PUSH(push),
    .FIFO_WDATA(f_wd), .TX_EN(tx_en), .TX_IDLE(tx_idle), .RX_EN(rx_en),
    .RX_DONE(rx_done), .EE_REQ(ee_req), .EE_WE(ee_we), .EE_ADDR(ee_addr),
    .EE_WDATA(ee_wd), .EE_ACK(ee_ack), .EE_RDATA(ee_rd), .REG_WE(reg_we),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wd), .KEY_WE(key_we), .KEY_IDX(key_ix),
    .KEY_WDATA(key_wd), .RNG_VALID(rng_valid), .RNG_DATA(rng_data));

  rcs_host_model u_host (.clk(clk), .ld(ld), .ld_data(ld_data), .clr(clr),
    .ee_lat(ee_lat), .fifo_pop(pop), .fifo_push(push), .fifo_wdata(f_wd),
    .fifo_rdata(f_rd), .fifo_empty(f_empty), .fifo_full(f_full),
    .fifo_level(f_lvl), .ee_req(ee_req), .ee_we(ee_we), .ee_addr(ee_addr),
    .ee_wdata(ee_wd), .ee_ack(ee_ack), .ee_rdata(ee_rd),
    .rng_valid(rng_valid), .rng_data(rng_data));

  always @(posedge clk)
  begin
    if (abort === 1'b1) n_abort++;
    if (reg_we === 1'b1) {n_reg, last_reg} = {n_reg + 1, reg_addr, reg_wd};
    if (key_we === 1'b1) {n_key, last_key} = {n_key + 1, key_ix, key_wd};
    if (push === 1'b1) pq.push_back(f_wd);
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // host starts work only by command writes
  task cmd(input logic [7:0] c);
    cmd_wr = 1'b1;
    cmd_wdata = c;
    @(negedge clk);
    cmd_wr = 1'b0;
    @(negedge clk);
  endtask
  task putq(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      ld = 1'b1;
      ld_data = b[i];
      @(negedge clk);
    end
    ld = 1'b0;
    @(negedge clk);
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 3000; i++)
    begin
      if (cmd_value === 8'h00) break;
      @(negedge clk);
    end
    if (i == 3000)
    begin
      chk("idle wait", 16'h0000, {8'h00, cmd_value});
      conclude();
    end
    repeat (2) @(negedge clk);
  endtask
  task clear_counts;
    {n_abort, n_reg, n_key} = '0;
    pq.delete();
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("reset value", 8'h00, cmd_value);
    chk("reset busy", 3'h0, {tx_en, rx_en, ee_req});
    foreach (rows[i])
    begin
      clear_counts();
      cmd(rows[i].code);
      wait_idle();
      chk("aborts", rows[i].ab, n_abort);
      chk("reg writes", rows[i].nreg, n_reg);
      chk("pushes", rows[i].npush, pq.size());
      $display("row %0d done", i);
    end
    clear_counts();
    tx_idle = 1'b0;
    cmd(8'h06);
    chk("tx start", 1'b1, tx_en);
    repeat (5) @(negedge clk);
    chk("tx busy", 1'b1, tx_en);
    tx_idle = 1'b1;
    wait_idle();
    chk("tx end", 1'b0, tx_en);
    tx_idle = 1'b0;
    cmd(8'h06);
    cmd(8'h00);
    chk("tx stop", 1'b0, tx_en);
    chk("idle value", 8'h00, cmd_value);
    tx_idle = 1'b1;
    $display("transmit done");
    multi = 1'b1;
    cmd(8'h07);
    repeat (4) @(negedge clk);
    chk("trx rx", 1'b1, rx_en);
    rx_done = 1'b1;
    @(negedge clk);
    rx_done = 1'b0;
    repeat (4) @(negedge clk);
    chk("multi rx", 1'b1, rx_en);
    chk("multi value", 8'h07, cmd_value);
    cmd(8'h00);
    multi = 1'b0;
    cmd(8'h07);
    repeat (4) @(negedge clk);
    rx_done = 1'b1;
    @(negedge clk);
    rx_done = 1'b0;
    wait_idle();
    chk("rx end", 1'b0, rx_en);
    $display("transceive done");
    putq('{8'h00, 8'h04});
    cmd(8'h08);
    repeat (20) @(negedge clk);
    chk("byte wait", 8'h08, cmd_value);
    putq('{8'h3C});
    wait_idle();
    chk("byte write", 8'h3C, u_host.mem[13'h0400]);
    putq('{8'h11, 8'hAA, 8'hBB});
    cmd(8'h09);
    wait_idle();
    chk("page first", 8'hAA, u_host.mem[13'h0440]);
    chk("page second", 8'hBB, u_host.mem[13'h0441]);
    $display("eeprom write done");
    putq('{8'h01, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h21, 8'h22,
      8'h23, 8'h24, 8'h25, 8'h26, 8'h31, 8'h32, 8'h33});
    cmd(8'h0F);
    wait_idle();
    chk("key first", 8'h11, u_host.mem[13'h0406]);
    chk("key next", 8'h26, u_host.mem[13'h0411]);
    chk("key rest", 10'h003, f_lvl);
    clear_counts();
    putq('{8'h01});
    cmd(8'h0E);
    wait_idle();
    chk("key loads", 16'h0006, n_key);
    chk("key last", 16'h0516, last_key);
    $display("keys done");
    ee_lat = 4'h6;
    clear_counts();
    putq('{8'hFE, 8'h06, 8'h02});
    cmd(8'h0A);
    wait_idle();
    chk("read count", 16'h0002, pq.size());
    chk("read first", 8'h5B, pq[0]);
    chk("read last", 8'h5A, pq[1]);
    ee_lat = 4'h1;
    clear_counts();
    putq('{8'h00, 8'h01, 8'h30, 8'h03});
    cmd(8'h0C);
    wait_idle();
    chk("load count", 16'h0003, n_reg);
    chk("load addr", 8'h32, last_reg[15:8]);
    chk("load data", 8'hA7, last_reg[7:0]);
    clear_counts();
    putq('{8'h00, 8'h12});
    cmd(8'h0D);
    wait_idle();
    chk("preset reserved", 16'h0001, n_abort);
    clear_counts();
    putq('{8'h11, 8'h11});
    cmd(8'h0D);
    wait_idle();
    chk("preset writes", 16'h0010, n_reg);
    $display("loads done");
    conclude();
  end
endmodule // reader_command_sequencer_bench

/* src/rcs_defines.vh */
// Operation
// - code 06h starts RF transmit at once
// - transmit ends on empty FIFO with TX_IDLE high, or on command
// - code 07h transmits then switches to receive
// - only command writes start a transmission
// - multi-frame receive keeps receiving until a command write
// - 08h writes one EEPROM byte, waits data
// - 09h writes up to 64 page bytes
// - 0Ah copies up to 256 bytes to FIFO
// - burst read address runs on past key area end, never reaching top
// - 0Ch copies EEPROM bytes into registers
// - 0Dh loads receive and transmit presets
// - receive preset numbers select receive protocols
// - transmit presets 00 to 17, 18 reserved
// - 0Eh loads stored key into crypto unit
// - 0Fh stores first key at given slot
// - further complete keys go to next slots
// - trailing partial key stays in FIFO
// - 1Ch fills FIFO with random bytes
// - 1Fh reloads register defaults from EEPROM
// - idle code 00h stops current command
// - command value returns idle when finished
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define RCS_CMD_IDLE 8'h00
`define RCS_CMD_TX 8'h06
`define RCS_CMD_TRX 8'h07
`define RCS_CMD_EEWR 8'h08
`define RCS_CMD_EEPG 8'h09
`define RCS_CMD_EERD 8'h0A
`define RCS_CMD_RLOAD 8'h0C
`define RCS_CMD_PLOAD 8'h0D
`define RCS_CMD_KLOAD 8'h0E
`define RCS_CMD_KSTORE 8'h0F
`define RCS_CMD_RNG 8'h1C
`define RCS_CMD_SRST 8'h1F

// ----------------------------------------
// parameter counts
// ----------------------------------------
`define RCS_NP_EEWR 3'h2
`define RCS_NP_EEPG 3'h1
`define RCS_NP_EERD 3'h3
`define RCS_NP_RLOAD 3'h4
`define RCS_NP_PLOAD 3'h2
`define RCS_NP_KEY 3'h1

// ----------------------------------------
// eeprom map
// ----------------------------------------
`define RCS_KEY_BASE 13'h0400
`define RCS_KEY_END 13'h06FF
`define RCS_KEY_SLOTS 8'h80
`define RCS_KEY_LEN 9'h006
`define RCS_KEY_STEP 13'h0006
`define RCS_PAGE_LO 7'h10
`define RCS_PAGE_HI 7'h1B
`define RCS_PAGE_LEN 9'h040
`define RCS_BURST_MAX 9'h100
`define RCS_SEC2_LO 13'h0100
`define RCS_SEC2_HI 13'h01FF
`define RCS_RXP_BASE 13'h0100
`define RCS_TXP_BASE 13'h0200
`define RCS_PSET_STEP 13'h0008
`define RCS_PSET_LEN 9'h008
`define RCS_PSET_NUM 8'h12
`define RCS_RX_REG_BASE 8'h40
`define RCS_TX_REG_BASE 8'h28
`define RCS_DEF_BASE 13'h0000
`define RCS_DEF_REG 8'h01
`define RCS_DEF_LEN 9'h07F

// ----------------------------------------
// copy destinations
// ----------------------------------------
`define RCS_DST_FIFO 2'h0
`define RCS_DST_REG 2'h1
`define RCS_DST_KEY 2'h2

`endif

/* src/rcs_param_file.v */
`timescale 1ns/1ps
module rcs_param_file
#(
  parameter NUM = 4,
  parameter W = 8
)
(
  input wire clk,
  input wire rst_n,
  input wire wr_en,
  input wire [1:0] wr_idx,
  input wire [W-1:0] wr_data,
  output wire [NUM*W-1:0] rd_flat
);

  genvar i;
  generate
    for (i = 0; i < NUM; i = i + 1)
    begin : g_ent
      reg [W-1:0] ent_reg;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          ent_reg <= {W{1'b0}};
        else if (wr_en && (wr_idx == i))
          ent_reg <= wr_data;
      end
      assign rd_flat[i*W +: W] = ent_reg;
    end
  endgenerate

endmodule // rcs_param_file

/* src/rcs_sequencer.v */
`timescale 1ns/1ps
`include "rcs_defines.vh"
module rcs_sequencer
#(
  parameter LW = 10
)
(
  input wire CLK_SYS,
  input wire RST_N,
  input wire CMD_WR,
  input wire [7:0] CMD_WDATA,
  output wire [7:0] CMD_VALUE,
  output wire CMD_ABORT,
  input wire MULTI_FRAME_RECEIVE,
  input wire [7:0] FIFO_RDATA,
  input wire FIFO_EMPTY,
  input wire FIFO_FULL,
  input wire [LW-1:0] FIFO_LEVEL,
  output wire FIFO_POP,
  output wire FIFO_PUSH,
  output wire [7:0] FIFO_WDATA,
  output wire TX_EN,
  input wire TX_IDLE,
  output wire RX_EN,
  input wire RX_DONE,
  output wire EE_REQ,
  output wire EE_WE,
  output wire [12:0] EE_ADDR,
  output wire [7:0] EE_WDATA,
  input wire EE_ACK,
  input wire [7:0] EE_RDATA,
  output wire REG_WE,
  output wire [7:0] REG_ADDR,
  output wire [7:0] REG_WDATA,
  output wire KEY_WE,
  output wire [2:0] KEY_IDX,
  output wire [7:0] KEY_WDATA,
  input wire RNG_VALID,
  input wire [7:0] RNG_DATA
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam S_IDLE = 10'h001;
  localparam S_TX = 10'h002;
  localparam S_RX = 10'h004;
  localparam S_PARM = 10'h008;
  localparam S_CHK = 10'h010;
  localparam S_FWR = 10'h020;
  localparam S_ERD = 10'h040;
  localparam S_PUT = 10'h080;
  localparam S_RNG = 10'h100;
  localparam S_NEXT = 10'h200;

  reg [9:0] state_reg, state_next;
  reg [7:0] cmd_reg, cmd_next;
  reg [8:0] cnt_reg, cnt_next;
  reg [12:0] ee_addr_reg, ee_addr_next;
  reg [7:0] reg_addr_reg, reg_addr_next;
  reg [2:0] key_idx_reg, key_idx_next;
  reg [7:0] slot_reg, slot_next;
  reg [1:0] dest_reg, dest_next;
  reg [2:0] p_cnt_reg, p_cnt_next;
  reg [2:0] p_need_reg, p_need_next;
  reg first_reg, first_next;
  reg wait_ok_reg, wait_ok_next;
  reg pop_reg, pop_next;
  reg push_reg, push_next;
  reg [7:0] fifo_wdata_reg, fifo_wdata_next;
  reg ee_req_reg, ee_req_next;
  reg ee_we_reg, ee_we_next;
  reg [7:0] ee_wdata_reg, ee_wdata_next;
  reg [7:0] byte_reg, byte_next;
  reg reg_we_reg, reg_we_next;
  reg key_we_reg, key_we_next;
  reg tx_en_reg, tx_en_next;
  reg rx_en_reg, rx_en_next;
  reg abort_reg, abort_next;
  reg done_c, fail_c;

  wire [31:0] par_flat;
  wire [7:0] p0 = par_flat[7:0];
  wire [7:0] p1 = par_flat[15:8];
  wire [7:0] p2 = par_flat[23:16];
  wire [7:0] p3 = par_flat[31:24];
  wire [12:0] par_addr = {p1[4:0], p0};
  wire addr_hi_ok = (p1[7:5] == 3'h0);
  wire in_keys = addr_hi_ok && (par_addr >= `RCS_KEY_BASE) &&
    (par_addr <= `RCS_KEY_END);
  wire in_sec2 = addr_hi_ok && (par_addr >= `RCS_SEC2_LO) &&
    (par_addr <= `RCS_SEC2_HI);
  wire page_ok = (p0[7] == 1'b0) && (p0[6:0] >= `RCS_PAGE_LO) &&
    (p0[6:0] <= `RCS_PAGE_HI);
  wire [12:0] slot_addr = `RCS_KEY_BASE + {5'h00, p0} * `RCS_KEY_STEP;
  wire [12:0] rxp_addr = `RCS_RXP_BASE + {5'h00, p0} * `RCS_PSET_STEP;
  wire [12:0] txp_addr = `RCS_TXP_BASE + {5'h00, p1} * `RCS_PSET_STEP;
  wire [LW+8:0] lvl_ext = {9'h000, FIFO_LEVEL};
  wire key_avail = (lvl_ext >= {{LW{1'b0}}, `RCS_KEY_LEN});
  wire par_wr = (state_reg == S_PARM) && !pop_reg &&
    (p_cnt_reg != p_need_reg) && !FIFO_EMPTY;

  rcs_param_file #(.NUM(4), .W(8)) u_par (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .wr_en(par_wr),
    .wr_idx(p_cnt_reg[1:0]),
    .wr_data(FIFO_RDATA),
    .rd_flat(par_flat)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @*
  begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    cnt_next = cnt_reg;
    ee_addr_next = ee_addr_reg;
    reg_addr_next = reg_addr_reg;
    key_idx_next = key_idx_reg;
    slot_next = slot_reg;
    dest_next = dest_reg;
    p_cnt_next = p_cnt_reg;
    p_need_next = p_need_reg;
    first_next = first_reg;
    wait_ok_next = wait_ok_reg;
    pop_next = 1'b0;
    push_next = 1'b0;
    fifo_wdata_next = fifo_wdata_reg;
    ee_req_next = ee_req_reg;
    ee_we_next = ee_we_reg;
    ee_wdata_next = ee_wdata_reg;
    byte_next = byte_reg;
    reg_we_next = 1'b0;
    key_we_next = 1'b0;
    tx_en_next = tx_en_reg;
    rx_en_next = rx_en_reg;
    abort_next = 1'b0;
    done_c = 1'b0;
    fail_c = 1'b0;
    case (state_reg)
      S_TX:
      begin
        if (FIFO_EMPTY && TX_IDLE && !pop_reg)
        begin
          tx_en_next = 1'b0;
          if (cmd_reg == `RCS_CMD_TRX)
          begin
            rx_en_next = 1'b1;
            state_next = S_RX;
          end
          else
            done_c = 1'b1;
        end
      end
      S_RX:
      begin
        if (RX_DONE && !MULTI_FRAME_RECEIVE)
          done_c = 1'b1;
      end
      S_PARM:
      begin
        // fifo flags lag a pop by one cycle, so pops are spaced
        if (pop_reg)
          pop_next = 1'b0;
        else if (p_cnt_reg == p_need_reg)
          state_next = S_CHK;
        else if (FIFO_EMPTY)
          fail_c = 1'b1;
        else
        begin
          pop_next = 1'b1;
          p_cnt_next = p_cnt_reg + 3'h1;
        end
      end
      S_CHK:
      begin
        state_next = S_ERD;
        case (cmd_reg)
          `RCS_CMD_EEWR:
          begin
            fail_c = !in_keys;
            ee_addr_next = par_addr;
            cnt_next = 9'h001;
            wait_ok_next = 1'b1;
            state_next = S_FWR;
          end
          `RCS_CMD_EEPG:
          begin
            fail_c = !page_ok;
            ee_addr_next = {p0[6:0], 6'h00};
            cnt_next = `RCS_PAGE_LEN;
            first_next = 1'b1;
            state_next = S_FWR;
          end
          `RCS_CMD_EERD:
          begin
            // length zero means the full 256
            fail_c = !in_keys;
            ee_addr_next = par_addr;
            cnt_next = (p2 == 8'h00) ? `RCS_BURST_MAX : {1'b0, p2};
            dest_next = `RCS_DST_FIFO;
          end
          `RCS_CMD_RLOAD:
          begin
            fail_c = !in_sec2;
            done_c = in_sec2 && (p3 == 8'h00);
            ee_addr_next = par_addr;
            reg_addr_next = p2;
            cnt_next = {1'b0, p3};
            dest_next = `RCS_DST_REG;
          end
          `RCS_CMD_PLOAD:
          begin
            fail_c = (p0 >= `RCS_PSET_NUM) || (p1 >= `RCS_PSET_NUM);
            ee_addr_next = rxp_addr;
            reg_addr_next = `RCS_RX_REG_BASE;
            cnt_next = `RCS_PSET_LEN;
            dest_next = `RCS_DST_REG;
          end
          `RCS_CMD_KLOAD:
          begin
            fail_c = (p0 >= `RCS_KEY_SLOTS);
            ee_addr_next = slot_addr;
            cnt_next = `RCS_KEY_LEN;
            key_idx_next = 3'h0;
            dest_next = `RCS_DST_KEY;
          end
          default:
          begin
            fail_c = (p0 >= `RCS_KEY_SLOTS) || !key_avail;
            slot_next = p0;
            ee_addr_next = slot_addr;
            cnt_next = `RCS_KEY_LEN;
            state_next = S_FWR;
          end
        endcase
      end
      S_FWR:
      begin
        if (ee_req_reg)
        begin
          if (EE_ACK)
          begin
            ee_req_next = 1'b0;
            cnt_next = cnt_reg - 9'h001;
            ee_addr_next = ee_addr_reg + 13'h0001;
            if (cnt_reg == 9'h001)
              state_next = S_NEXT;
          end
        end
        else if (pop_reg)
          pop_next = 1'b0;
        else if (FIFO_EMPTY)
        begin
          if (!wait_ok_reg)
          begin
            done_c = (cmd_reg == `RCS_CMD_EEPG) && !first_reg;
            fail_c = !done_c;
          end
        end
        else
        begin
          pop_next = 1'b1;
          first_next = 1'b0;
          ee_wdata_next = FIFO_RDATA;
          ee_req_next = 1'b1;
          ee_we_next = 1'b1;
        end
      end
      S_NEXT:
      begin
        done_c = 1'b1;
        if ((cmd_reg == `RCS_CMD_KSTORE) && key_avail &&
          (slot_reg + 8'h01 < `RCS_KEY_SLOTS))
        begin
          done_c = 1'b0;
          slot_next = slot_reg + 8'h01;
          cnt_next = `RCS_KEY_LEN;
          state_next = S_FWR;
        end
      end
      S_ERD:
      begin
        if (!ee_req_reg)
        begin
          ee_req_next = 1'b1;
          ee_we_next = 1'b0;
        end
        else if (EE_ACK)
        begin
          ee_req_next = 1'b0;
          byte_next = EE_RDATA;
          state_next = S_PUT;
        end
      end
      S_PUT:
      begin
        if (!((dest_reg == `RCS_DST_FIFO) && FIFO_FULL))
        begin
          push_next = (dest_reg == `RCS_DST_FIFO);
          fifo_wdata_next = byte_reg;
          reg_we_next = (dest_reg == `RCS_DST_REG);
          key_we_next = (dest_reg == `RCS_DST_KEY);
          cnt_next = cnt_reg - 9'h001;
          ee_addr_next = ee_addr_reg + 13'h0001;
          state_next = S_ERD;
          if (cnt_reg == 9'h001)
          begin
            if ((cmd_reg == `RCS_CMD_PLOAD) &&
              (reg_addr_reg < `RCS_RX_REG_BASE))
              done_c = 1'b1;
            else if (cmd_reg == `RCS_CMD_PLOAD)
            begin
              ee_addr_next = txp_addr;
              cnt_next = `RCS_PSET_LEN;
            end
            else
              done_c = 1'b1;
          end
        end
      end
      S_RNG:
      begin
        if (push_reg)
          push_next = 1'b0;
        else if (FIFO_FULL)
          done_c = 1'b1;
        else if (RNG_VALID)
        begin
          push_next = 1'b1;
          fifo_wdata_next = RNG_DATA;
        end
      end
      default:
        state_next = S_IDLE;
    endcase
    // register address advances after each register write, but moves to RCS_TX_REG_BASE after the last receive preset write
    if (reg_we_reg)
    begin
      reg_addr_next = reg_addr_reg + 8'h01;
      if ((cmd_reg == `RCS_CMD_PLOAD) && (state_reg == S_ERD) &&
        (cnt_reg == `RCS_PSET_LEN) &&
        (reg_addr_reg == `RCS_RX_REG_BASE + 8'h07))
        reg_addr_next = `RCS_TX_REG_BASE;
    end
    if (key_we_reg)
      key_idx_next = key_idx_reg + 3'h1;
    if (done_c || fail_c)
    begin
      state_next = S_IDLE;
      cmd_next = `RCS_CMD_IDLE;
      ee_req_next = 1'b0;
      tx_en_next = 1'b0;
      rx_en_next = 1'b0;
      abort_next = fail_c;
    end
    if (CMD_WR)
    begin
      cmd_next = CMD_WDATA;
      state_next = S_IDLE;
      pop_next = 1'b0;
      push_next = 1'b0;
      ee_req_next = 1'b0;
      tx_en_next = 1'b0;
      rx_en_next = 1'b0;
      abort_next = 1'b0;
      p_cnt_next = 3'h0;
      wait_ok_next = 1'b0;
      case (CMD_WDATA)
        `RCS_CMD_TX, `RCS_CMD_TRX:
        begin
          tx_en_next = 1'b1;
          state_next = S_TX;
        end
        `RCS_CMD_EEWR:
        begin
          p_need_next = `RCS_NP_EEWR;
          state_next = S_PARM;
        end
        `RCS_CMD_EEPG:
        begin
          p_need_next = `RCS_NP_EEPG;
          state_next = S_PARM;
        end
        `RCS_CMD_EERD:
        begin
          p_need_next = `RCS_NP_EERD;
          state_next = S_PARM;
        end
        `RCS_CMD_RLOAD:
        begin
          p_need_next = `RCS_NP_RLOAD;
          state_next = S_PARM;
        end
        `RCS_CMD_PLOAD:
        begin
          p_need_next = `RCS_NP_PLOAD;
          state_next = S_PARM;
        end
        `RCS_CMD_KLOAD, `RCS_CMD_KSTORE:
        begin
          p_need_next = `RCS_NP_KEY;
          state_next = S_PARM;
        end
        `RCS_CMD_RNG:
          state_next = S_RNG;
        `RCS_CMD_SRST:
        begin
          ee_addr_next = `RCS_DEF_BASE;
          reg_addr_next = `RCS_DEF_REG;
          cnt_next = `RCS_DEF_LEN;
          dest_next = `RCS_DST_REG;
          state_next = S_ERD;
        end
        default:
          state_next = S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_reg <= S_IDLE;
      cmd_reg <= `RCS_CMD_IDLE;
      cnt_reg <= 9'h000;
      ee_addr_reg <= 13'h0000;
      reg_addr_reg <= 8'h00;
      key_idx_reg <= 3'h0;
      slot_reg <= 8'h00;
      dest_reg <= `RCS_DST_FIFO;
      p_cnt_reg <= 3'h0;
      p_need_reg <= 3'h0;
      first_reg <= 1'b0;
      wait_ok_reg <= 1'b0;
      pop_reg <= 1'b0;
      push_reg <= 1'b0;
      fifo_wdata_reg <= 8'h00;
      ee_req_reg <= 1'b0;
      ee_we_reg <= 1'b0;
      ee_wdata_reg <= 8'h00;
      byte_reg <= 8'h00;
      reg_we_reg <= 1'b0;
      key_we_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      abort_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      cnt_reg <= cnt_next;
      ee_addr_reg <= ee_addr_next;
      reg_addr_reg <= reg_addr_next;
      key_idx_reg <= key_idx_next;
      slot_reg <= slot_next;
      dest_reg <= dest_next;
      p_cnt_reg <= p_cnt_next;
      p_need_reg <= p_need_next;
      first_reg <= first_next;
      wait_ok_reg <= wait_ok_next;
      pop_reg <= pop_next;
      push_reg <= push_next;
      fifo_wdata_reg <= fifo_wdata_next;
      ee_req_reg <= ee_req_next;
      ee_we_reg <= ee_we_next;
      ee_wdata_reg <= ee_wdata_next;
      byte_reg <= byte_next;
      reg_we_reg <= reg_we_next;
      key_we_reg <= key_we_next;
      tx_en_reg <= tx_en_next;
      rx_en_reg <= rx_en_next;
      abort_reg <= abort_next;
    end
  end

  assign CMD_VALUE = cmd_reg;
  assign CMD_ABORT = abort_reg;
  assign FIFO_POP = pop_reg;
  assign FIFO_PUSH = push_reg;
  assign FIFO_WDATA = fifo_wdata_reg;
  assign TX_EN = tx_en_reg;
  assign RX_EN = rx_en_reg;
  assign EE_REQ = ee_req_reg;
  assign EE_WE = ee_we_reg;
  assign EE_ADDR = ee_addr_reg;
  assign EE_WDATA = ee_wdata_reg;
  assign REG_WE = reg_we_reg;
  assign REG_ADDR = reg_addr_reg;
  assign REG_WDATA = byte_reg;
  assign KEY_WE = key_we_reg;
  assign KEY_IDX = key_idx_reg;
  assign KEY_WDATA = byte_reg;

endmodule // rcs_sequencer
